// >>> core/besl_pkg.sv
// Shared constants and carrier types for the bus error status logger.
// Assumes a single 100 MHz core clock and a classic Wishbone register bus.
package besl_pkg;

    localparam int unsigned CLK_MHZ = 100;

    // Register byte offsets.
    localparam logic [7:0] STATUS_LO_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_HI_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
    localparam logic [7:0] CTRL_OFFSET = 8'h10;
    localparam logic [7:0] WDOG_OFFSET = 8'h14;

    // Status bit positions.
    localparam int unsigned ERR_TYPE_LSB = 25;
    localparam int unsigned MCE_DRIVEN_BIT = 28;
    localparam int unsigned MCE_OBSERVED_BIT = 29;
    localparam int unsigned BUS_INIT_SIGNAL_DRIVEN_BIT = 30;
    localparam int unsigned BUS_INIT_SIGNAL_OBSERVED_BIT = 31;
    localparam int unsigned DATA_PARITY_BIT = 34;
    localparam int unsigned RESP_PARITY_BIT = 36;
    localparam int unsigned ADDR_PARITY_BIT = 37;
    localparam int unsigned TIMEOUT_BIT = 38;
    localparam int unsigned HARD_ERR_BIT = 42;
    localparam int unsigned INTERNAL_ERROR_PIN_BIT = 43;
    localparam int unsigned OVERFLOW_BIT = 62;
    localparam int unsigned VALID_BIT = 63;

    // Bits that hold state; all others are reserved and read zero.
    localparam logic [63:0] STATUS_RW_MASK = 64'hFE00_0C74_FFF8_FFFF;
    localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;

    typedef enum logic [2:0] {
        BESL_ERR_NONE = 3'h0,
        BESL_ERR_ADDR_PARITY = 3'h1,
        BESL_ERR_HARD_RESP = 3'h2,
        BESL_ERR_RESP_PARITY = 3'h3
    } besl_err_type;

    // Interrupt status and mask bit positions.
    localparam int unsigned IRQ_ADDR_PAR = 0;
    localparam int unsigned IRQ_HARD = 1;
    localparam int unsigned IRQ_RESP_PAR = 2;
    localparam int unsigned IRQ_DATA_PAR = 3;
    localparam int unsigned IRQ_MCE_OBS = 4;
    localparam int unsigned IRQ_BUS_INIT_SIGNAL_OBS = 5;
    localparam int unsigned IRQ_TIMEOUT = 6;
    localparam int unsigned IRQ_INTERNAL_ERROR_PIN = 7;
    localparam int unsigned IRQ_W = 8;
    localparam logic [7:0] IRQ_RESET = 8'h00;

    // Control register: bus clock ratio in [1:0], machine check drive in [2].
    localparam int unsigned CTRL_RATIO_LSB = 0;
    localparam int unsigned CTRL_MCE_EN_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h4;
    localparam logic [1:0] RATIO_1_2 = 2'h0;
    localparam logic [1:0] RATIO_1_3 = 2'h1;
    localparam logic [1:0] RATIO_1_4 = 2'h2;

    // Watchdog structure.
    localparam int unsigned PIC_W = 8;
    localparam int unsigned PIC_DIV = 128;
    localparam int unsigned ROB_W = 23;

    typedef struct packed {
        logic machine_check_signal;
        logic bus_init_signal;
        logic [2:0] rs;
        logic rsp;
        logic resp_valid;
    } besl_pins_type;

    typedef struct packed {
        logic retire;
        logic exception;
        logic addr_parity;
        logic hard_resp;
        logic data_parity;
        logic internal_fail;
    } besl_core_evt_type;

    typedef enum logic [1:0] {
        BESL_WB_IDLE = 2'h0,
        BESL_WB_ACK = 2'h1
    } besl_wb_state_type;

endpackage

// >>> core/besl_logger.sv
// Bus error status logger: model specific machine check status bits,
// retirement watchdog and a Wishbone register slave.
// Assumes bus pins are asynchronous and core events share clk_i.
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/100ps

module besl_logger #(
    parameter int unsigned ROB_BITS = besl_pkg::ROB_W,
    parameter int unsigned PIC_PRESCALE = besl_pkg::PIC_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire besl_pkg::besl_pins_type pins_i,
    input wire besl_pkg::besl_core_evt_type core_evt_i,
    output logic machine_check_drive_o,
    output logic bus_init_drive_o,
    output logic internal_error_pin_o,
    output logic irq_o
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Pin synchronisers; only the second stage is read by logic.
    besl_pkg::besl_pins_type sync1;
    besl_pkg::besl_pins_type sync2;
    logic mce_prev;
    logic bus_init_signal_prev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            mce_prev <= 1'b0;
            bus_init_signal_prev <= 1'b0;
        end else begin
            sync1 <= pins_i;
            sync2 <= sync1;
            mce_prev <= sync2.machine_check_signal;
            bus_init_signal_prev <= sync2.bus_init_signal;
        end
    end

    logic mce_seen;
    logic bus_init_signal_seen;
    logic resp_par_err;
    assign mce_seen = sync2.machine_check_signal && !mce_prev;
    assign bus_init_signal_seen = sync2.bus_init_signal && !bus_init_signal_prev;
    // Even parity over the three lines and the check pin.
    assign resp_par_err = sync2.resp_valid && (^{sync2.rs, sync2.rsp});

    // Register bus slave.
    besl_pkg::besl_wb_state_type wb_state;
    besl_pkg::besl_wb_state_type next_wb_state;
    logic [31:0] next_wb_dat;
    logic wr_en;
    logic [63:0] status;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [2:0] ctrl;
    logic [ROB_BITS-1:0] rob_cnt;

    assign wr_en = (wb_state == besl_pkg::BESL_WB_ACK) && wb_cyc_i
        && wb_stb_i && wb_we_i;
    assign wb_ack_o = (wb_state == besl_pkg::BESL_WB_ACK);

    always_comb begin
        next_wb_state = wb_state;
        next_wb_dat = wb_dat_o;
        case (wb_state)
            besl_pkg::BESL_WB_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    next_wb_state = besl_pkg::BESL_WB_ACK;
                    case (wb_adr_i)
                        besl_pkg::STATUS_LO_OFFSET: next_wb_dat = status[31:0];
                        besl_pkg::STATUS_HI_OFFSET: next_wb_dat = status[63:32];
                        besl_pkg::IRQ_STAT_OFFSET: next_wb_dat = {24'h000000, irq_stat};
                        besl_pkg::IRQ_MASK_OFFSET: next_wb_dat = {24'h000000, irq_mask};
                        besl_pkg::CTRL_OFFSET: next_wb_dat = {29'h00000000, ctrl};
                        besl_pkg::WDOG_OFFSET: next_wb_dat = 32'(rob_cnt);
                        default: next_wb_dat = 32'h00000000;
                    endcase
                end
            end
            besl_pkg::BESL_WB_ACK: begin
                next_wb_state = besl_pkg::BESL_WB_IDLE;
            end
            default: begin
                next_wb_state = besl_pkg::BESL_WB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_state <= besl_pkg::BESL_WB_IDLE;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_state <= next_wb_state;
            wb_dat_o <= next_wb_dat;
        end
    end

    // Bus clock tick, prescaler and retirement watchdog.
    logic [1:0] bus_div;
    logic [1:0] next_bus_div;
    logic [6:0] pre_div;
    logic [6:0] next_pre_div;
    logic [besl_pkg::PIC_W-1:0] pic_cnt;
    logic [besl_pkg::PIC_W-1:0] next_pic_cnt;
    logic [ROB_BITS-1:0] next_rob_cnt;
    logic [1:0] ratio_max;
    logic bus_tick;
    logic pic_tick;
    logic pic_carry;
    logic rob_carry;
    logic rob_clear;

    always_comb begin
        case (ctrl[1:0])
            besl_pkg::RATIO_1_3: ratio_max = 2'h2;
            besl_pkg::RATIO_1_4: ratio_max = 2'h3;
            default: ratio_max = 2'h1;
        endcase
        bus_tick = (bus_div == ratio_max);
        next_bus_div = bus_tick ? 2'h0 : bus_div + 2'h1;
        pic_tick = bus_tick && (pre_div == 7'(PIC_PRESCALE - 1));
        next_pre_div = pre_div;
        if (bus_tick) begin
            next_pre_div = pic_tick ? 7'h00 : pre_div + 7'h01;
        end
        pic_carry = pic_tick && (&pic_cnt);
        next_pic_cnt = pic_tick ? pic_cnt + 8'h01 : pic_cnt;
        rob_carry = pic_carry && (&rob_cnt);
        rob_clear = core_evt_i.retire || core_evt_i.exception || rob_carry;
        next_rob_cnt = rob_cnt;
        if (rob_clear) begin
            next_rob_cnt = '0;
        end else if (pic_carry) begin
            next_rob_cnt = rob_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_div <= 2'h0;
            pre_div <= 7'h00;
            pic_cnt <= 8'h00;
            rob_cnt <= '0;
        end else begin
            bus_div <= next_bus_div;
            pre_div <= next_pre_div;
            pic_cnt <= next_pic_cnt;
            rob_cnt <= next_rob_cnt;
        end
    end

    // Status logging, interrupts and control.
    logic [63:0] next_status;
    logic [63:0] hw_set;
    logic [7:0] next_irq_stat;
    logic [7:0] next_irq_mask;
    logic [7:0] irq_evt;
    logic [2:0] next_ctrl;
    logic next_mce_drive;
    logic bus_err;

    always_comb begin
        hw_set = 64'h0000_0000_0000_0000;
        bus_err = core_evt_i.addr_parity || core_evt_i.hard_resp
            || resp_par_err;
        hw_set[besl_pkg::MCE_OBSERVED_BIT] = mce_seen;
        hw_set[besl_pkg::BUS_INIT_SIGNAL_DRIVEN_BIT] = rob_carry;
        hw_set[besl_pkg::BUS_INIT_SIGNAL_OBSERVED_BIT] = bus_init_signal_seen;
        hw_set[besl_pkg::DATA_PARITY_BIT] = core_evt_i.data_parity;
        hw_set[besl_pkg::RESP_PARITY_BIT] = resp_par_err;
        hw_set[besl_pkg::ADDR_PARITY_BIT] = core_evt_i.addr_parity;
        hw_set[besl_pkg::TIMEOUT_BIT] = rob_carry;
        hw_set[besl_pkg::HARD_ERR_BIT] = core_evt_i.hard_resp;
        hw_set[besl_pkg::INTERNAL_ERROR_PIN_BIT] = core_evt_i.internal_fail;
        next_mce_drive = ctrl[besl_pkg::CTRL_MCE_EN_BIT]
            && (|hw_set) && !machine_check_drive_o;
        hw_set[besl_pkg::MCE_DRIVEN_BIT] = next_mce_drive;
        next_status = status;
        if (wr_en && wb_adr_i == besl_pkg::STATUS_LO_OFFSET) begin
            next_status[31:0] = merge_bytes(status[31:0], wb_dat_i, wb_sel_i);
        end
        if (wr_en && wb_adr_i == besl_pkg::STATUS_HI_OFFSET) begin
            next_status[63:32] = merge_bytes(status[63:32], wb_dat_i, wb_sel_i);
        end
        // Sticky bits are only ever ORed, so a new error cannot clear them.
        next_status = next_status | hw_set;
        if (bus_err) begin
            // Response parity outranks hard response, which outranks address.
            if (resp_par_err) begin
                next_status[27:25] = besl_pkg::BESL_ERR_RESP_PARITY;
            end else if (core_evt_i.hard_resp) begin
                next_status[27:25] = besl_pkg::BESL_ERR_HARD_RESP;
            end else begin
                next_status[27:25] = besl_pkg::BESL_ERR_ADDR_PARITY;
            end
        end
        if (|hw_set) begin
            next_status[besl_pkg::OVERFLOW_BIT] =
                next_status[besl_pkg::OVERFLOW_BIT]
                || status[besl_pkg::VALID_BIT];
            next_status[besl_pkg::VALID_BIT] = 1'b1;
        end
        next_status = next_status & besl_pkg::STATUS_RW_MASK;

        irq_evt = {core_evt_i.internal_fail, rob_carry, bus_init_signal_seen, mce_seen,
            core_evt_i.data_parity, resp_par_err, core_evt_i.hard_resp,
            core_evt_i.addr_parity};
        next_irq_stat = irq_stat;
        if (wr_en && wb_adr_i == besl_pkg::IRQ_STAT_OFFSET && wb_sel_i[0]) begin
            next_irq_stat = irq_stat & ~wb_dat_i[7:0];
        end
        // A set in the same cycle as its clear wins.
        next_irq_stat = next_irq_stat | irq_evt;
        next_irq_mask = irq_mask;
        if (wr_en && wb_adr_i == besl_pkg::IRQ_MASK_OFFSET && wb_sel_i[0]) begin
            next_irq_mask = wb_dat_i[7:0];
        end
        next_ctrl = ctrl;
        if (wr_en && wb_adr_i == besl_pkg::CTRL_OFFSET && wb_sel_i[0]) begin
            next_ctrl = wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= besl_pkg::STATUS_RESET;
            irq_stat <= besl_pkg::IRQ_RESET;
            irq_mask <= besl_pkg::IRQ_RESET;
            ctrl <= besl_pkg::CTRL_RESET;
            machine_check_drive_o <= 1'b0;
            bus_init_drive_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            status <= next_status;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            ctrl <= next_ctrl;
            machine_check_drive_o <= next_mce_drive;
            bus_init_drive_o <= rob_carry;
            irq_o <= |(next_irq_stat & next_irq_mask);
        end
    end

    assign internal_error_pin_o = status[besl_pkg::INTERNAL_ERROR_PIN_BIT];

    logic wr_hi;
    assign wr_hi = wr_en && (wb_adr_i == besl_pkg::STATUS_HI_OFFSET);

    a_resp_par_code: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_par_err |=> status[27:25] == 3'h3 && status[36])
        else $error("Response parity error not logged.");

    a_addr_par_code: assert property (@(posedge clk_i) disable iff (rst_i)
        core_evt_i.addr_parity && !core_evt_i.hard_resp && !resp_par_err
        |=> status[27:25] == 3'h1 && status[37])
        else $error("Address parity error not logged.");

    a_timeout_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        status[38] && !wr_hi |=> status[38])
        else $error("Timeout bit lost without a write.");

    a_hard_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (core_evt_i.hard_resp ##1 !wr_hi) |-> status[42])
        else $error("Hard error bit not held.");

    a_internal_error_pin_pin_held: assert property (@(posedge clk_i) disable iff (rst_i)
        core_evt_i.internal_fail |=> internal_error_pin_o [*2] or
        (internal_error_pin_o && wr_hi))
        else $error("Internal error pin not held.");

    a_rob_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        core_evt_i.retire || core_evt_i.exception |=> rob_cnt == '0)
        else $error("Watchdog not cleared.");

    a_rob_step: assert property (@(posedge clk_i) disable iff (rst_i)
        pic_carry && !rob_clear |=> rob_cnt == $past(rob_cnt) + 1'b1)
        else $error("Watchdog did not step by one.");

    a_timeout_bus_init_signal: assert property (@(posedge clk_i) disable iff (rst_i)
        rob_carry |=> bus_init_drive_o && status[38] && status[30]
        && rob_cnt == '0)
        else $error("Timeout did not drive bus init.");

    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (status & ~besl_pkg::STATUS_RW_MASK) == 64'h0000_0000_0000_0000)
        else $error("Reserved status bit set.");

    a_valid_on_log: assert property (@(posedge clk_i) disable iff (rst_i)
        (|hw_set) |=> status[63])
        else $error("Valid bit not set on logging.");

    a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle.");

endmodule // besl_logger

// >>> dv/besl_bus_agent.sv
// Behavioural model of the other agents on the front side bus.
// Assumes the bench raises requests by non-blocking assignment on clk_i.
`timescale 1ns/100ps

module besl_bus_agent (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic resp_req_i,
    input wire logic [2:0] resp_code_i,
    input wire logic bad_par_i,
    input wire logic mce_req_i,
    input wire logic bus_init_signal_req_i,
    output besl_pkg::besl_pins_type pins_o
);
    // Outside a response the status lines are not driven, so they toggle.
    // A logger that ignores the valid strobe then logs garbage and is seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_o <= '0;
        end else begin
            pins_o.machine_check_signal <= mce_req_i;
            pins_o.bus_init_signal <= bus_init_signal_req_i;
            pins_o.resp_valid <= resp_req_i;
            if (resp_req_i) begin
                pins_o.rs <= resp_code_i;
                pins_o.rsp <= (^resp_code_i) ^ bad_par_i;
            end else begin
                pins_o.rs <= ~pins_o.rs;
                pins_o.rsp <= ~pins_o.rsp;
            end
        end
    end
endmodule // besl_bus_agent

// >>> dv/testbench.sv
// Self-checking bench for the bus error status logger.
// Assumes the logger answers Wishbone one cycle after taking a request.
`timescale 1ns/100ps

module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [5:0] evt = 6'h00;
    logic resp_req = 1'b0;
    logic [2:0] resp_code = 3'h0;
    logic bad_par = 1'b0;
    logic mce_req = 1'b0;
    logic bus_init_signal_req = 1'b0;
    besl_pkg::besl_pins_type pins;
    logic mce_drive;
    logic bus_init_signal_drive;
    logic internal_error_pin_pin;
    logic irq_o;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    int n;

    always #5 clk_i = ~clk_i;

    // Small watchdog sizes keep a timeout at the 1:2 bus ratio near four thousand clocks.
    besl_logger #(.ROB_BITS(2), .PIC_PRESCALE(2)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pins_i(pins), .core_evt_i(besl_pkg::besl_core_evt_type'(evt)),
        .machine_check_drive_o(mce_drive), .bus_init_drive_o(bus_init_signal_drive),
        .internal_error_pin_o(internal_error_pin_pin), .irq_o(irq_o));

    besl_bus_agent u_agent (
        .clk_i(clk_i), .rst_i(rst_i), .resp_req_i(resp_req),
        .resp_code_i(resp_code), .bad_par_i(bad_par), .mce_req_i(mce_req),
        .bus_init_signal_req_i(bus_init_signal_req), .pins_o(pins));

    task automatic stop_test;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Enter and leave just after a rising edge; cyc stays low one cycle.
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] wd, output logic [31:0] q);
        int k;
        k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= wd;
        wb_sel <= 4'hF;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        if (k >= 50) begin
            num_errors++;
            $display("[FAIL] wb_ack expected 1 seen 0");
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] dummy;
        wb_cycle(1'b1, adr, wd, dummy);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] adr,
                          input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, adr, 32'h0000_0000, q);
        check(name, exp, q & mask);
    endtask

    task automatic clear_all;
        wr(besl_pkg::STATUS_LO_OFFSET, 32'h0000_0000);
        wr(besl_pkg::STATUS_HI_OFFSET, 32'h0000_0000);
        wr(besl_pkg::IRQ_STAT_OFFSET, 32'h0000_00FF);
    endtask

    // Core event bits: retire, exception, addr, hard, data, internal.
    task automatic pulse(input int idx);
        evt[idx] <= 1'b1;
        @(posedge clk_i);
        evt <= 6'h00;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic log_case(input string name, input int idx,
                            input logic [31:0] lo, input logic [31:0] hi);
        clear_all();
        pulse(idx);
        rd_chk({name, "_lo"}, besl_pkg::STATUS_LO_OFFSET, 32'hFFFF_FFFF, lo);
        rd_chk({name, "_hi"}, besl_pkg::STATUS_HI_OFFSET, 32'hFFFF_FFFF, hi);
    endtask

    task automatic resp(input logic [2:0] code, input logic bad);
        clear_all();
        resp_req <= 1'b1;
        resp_code <= code;
        bad_par <= bad;
        @(posedge clk_i);
        resp_req <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    // Timeout lands within one prescaler carry after rob reaches all ones.
    task automatic wdog(input logic [31:0] ctrl, input int f);
        wr(besl_pkg::CTRL_OFFSET, ctrl);
        clear_all();
        pulse(5);
        n = 0;
        while (bus_init_signal_drive !== 1'b1 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        // The prescaler is not cleared by retire, so three to four carries.
        check("timeout_window", 32'h1, (n >= 1536 * f - 8 && n <= 2048 * f + 20));
        repeat (6) @(posedge clk_i);
        rd_chk("timeout_hi", besl_pkg::STATUS_HI_OFFSET, 32'h40, 32'h40);
        rd_chk("bus_init_signal_drv", besl_pkg::STATUS_LO_OFFSET, 32'h4000_0000, 32'h4000_0000);
        rd_chk("wdog_clr", besl_pkg::WDOG_OFFSET, 32'hFFFF_FFFF, 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("rst_lo", besl_pkg::STATUS_LO_OFFSET, 32'hFFFF_FFFF, 32'h0);
        rd_chk("rst_hi", besl_pkg::STATUS_HI_OFFSET, 32'hFFFF_FFFF, 32'h0);
        rd_chk("rst_ctrl", besl_pkg::CTRL_OFFSET, 32'h7, 32'h4);
        rd_chk("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0);
        log_case("addr", 3, 32'h1200_0000, 32'h8000_0020);
        log_case("hard", 2, 32'h1400_0000, 32'h8000_0400);
        log_case("data", 1, 32'h1000_0000, 32'h8000_0004);
        log_case("internal_error_pin", 0, 32'h1000_0000, 32'h8000_0800);
        check("internal_error_pin_pin", 32'h1, {31'h0, internal_error_pin_pin});
        // A later error must leave the hard error bit in place.
        pulse(2);
        pulse(3);
        rd_chk("sticky_hi", besl_pkg::STATUS_HI_OFFSET, 32'hC000_0400, 32'hC000_0400);
        resp(3'h5, 1'b1);
        rd_chk("rpar_lo", besl_pkg::STATUS_LO_OFFSET, 32'h0E00_0000, 32'h0600_0000);
        rd_chk("rpar_hi", besl_pkg::STATUS_HI_OFFSET, 32'h0000_0010, 32'h0000_0010);
        resp(3'h2, 1'b0);
        rd_chk("rgood_hi", besl_pkg::STATUS_HI_OFFSET, 32'hFFFF_FFFF, 32'h0);
        clear_all();
        mce_req <= 1'b1;
        bus_init_signal_req <= 1'b1;
        repeat (4) @(posedge clk_i);
        mce_req <= 1'b0;
        bus_init_signal_req <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd_chk("observed", besl_pkg::STATUS_LO_OFFSET, 32'hA000_0000, 32'hA000_0000);
        wr(besl_pkg::STATUS_LO_OFFSET, 32'hFFFF_FFFF);
        wr(besl_pkg::STATUS_HI_OFFSET, 32'hFFFF_FFFF);
        rd_chk("resv_lo", besl_pkg::STATUS_LO_OFFSET, 32'hFFFF_FFFF, 32'hFFF8_FFFF);
        rd_chk("resv_hi", besl_pkg::STATUS_HI_OFFSET, 32'hFFFF_FFFF, 32'hFE00_0C74);
        // Interrupt raised, masked off, unmasked and cleared.
        clear_all();
        wr(besl_pkg::IRQ_MASK_OFFSET, 32'h0000_0002);
        pulse(2);
        check("irq_on", 32'h1, {31'h0, irq_o});
        wr(besl_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
        check("irq_mask", 32'h0, {31'h0, irq_o});
        wr(besl_pkg::IRQ_MASK_OFFSET, 32'h0000_0002);
        wr(besl_pkg::IRQ_STAT_OFFSET, 32'h0000_0002);
        rd_chk("irq_w1c", besl_pkg::IRQ_STAT_OFFSET, 32'hFF, 32'h0);
        check("irq_off", 32'h0, {31'h0, irq_o});
        // Retire and exception keep the watchdog quiet over ten 807-clock periods.
        n = 0;
        repeat (10) begin
            pulse(n % 2 == 0 ? 5 : 4);
            repeat (800) @(posedge clk_i);
            if (bus_init_signal_drive === 1'b1) n = 100;
            n++;
        end
        check("no_timeout", 32'h0, {31'h0, (n > 50)});
        wdog(32'h4, 2);
        wdog(32'h5, 3);
        wdog(32'h6, 4);
        stop_test();
    end
endmodule // testbench
